// ==== src/mdc_pkg.sv ====
// constants shared by the magnetometer register block
package mdc_pkg;
  // ****************************************
  // register indices, byte address = 4 * index
  // ****************************************
  localparam logic [7:0] IDX_STATUS = 8'h10;
  localparam logic [7:0] IDX_X_WORD = 8'h11;
  localparam logic [7:0] IDX_Y_WORD = 8'h12;
  localparam logic [7:0] IDX_Z_WORD = 8'h13;
  localparam logic [7:0] IDX_EVENT_ENABLE = 8'h20;
  localparam logic [7:0] IDX_MODE_CONTROL = 8'h21;
  localparam int IDX_LSB = 2;
  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam logic [15:0] EVEN_RESET = 16'h0601;
  localparam logic [15:0] EVEN_WMASK = 16'h07ff;
  localparam int EVEN_READY = 0;
  localparam int EVEN_SW_LSB = 1;
  localparam int EVEN_LATERAL = 7;
  localparam int EVEN_CONV = 8;
  localparam int EVEN_PP = 9;
  localparam int EVEN_OD = 10;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'h3f;
  localparam int MODE_DRIVE = 4;
  localparam int MODE_RANGE = 5;
  localparam int ST_READY = 0;
  localparam int ST_SW_LSB = 1;
  localparam int ST_LATERAL = 7;
  localparam int ST_CONV = 8;
  localparam int SW_EVENTS = 6;
  // ****************************************
  // operating modes and clamp limits
  // ****************************************
  localparam logic [3:0] MODE_POWER_DOWN = 4'h0;
  localparam logic [3:0] MODE_SINGLE = 4'h1;
  localparam logic [15:0] FULL_MAX = 16'h7fff;
  localparam logic [15:0] FULL_MIN = 16'h8000;
  localparam logic [15:0] WIDE_XY_MAX = 16'h2c00;
  localparam logic [15:0] WIDE_XY_MIN = 16'hd400;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ = 2'b11;
endpackage : mdc_pkg

// ==== src/mdc_clamp.sv ====
// saturation of one raw converter sample into a 16-bit axis word
`timescale 1ns/10ps
`default_nettype none
module mdc_clamp import mdc_pkg::*; #(
  parameter int RAW_W = 18,
  parameter bit LATERAL = 1'b1
) (
  // raw sample and range
  input wire logic [RAW_W-1:0] raw,
  input wire logic wide,
  // clamped word
  output logic [15:0] word,
  output logic sat
);
  logic [15:0] hi;
  logic [15:0] lo;
  logic signed [RAW_W-1:0] hi_x;
  logic signed [RAW_W-1:0] lo_x;

  // wide range narrows only the lateral axes
  assign hi = (wide && LATERAL) ? WIDE_XY_MAX : FULL_MAX;
  assign lo = (wide && LATERAL) ? WIDE_XY_MIN : FULL_MIN;
  assign hi_x = {{(RAW_W-16){hi[15]}}, hi};
  assign lo_x = {{(RAW_W-16){lo[15]}}, lo};

  always_comb begin
    word = raw[15:0];
    sat = 1'b0;
    if ($signed(raw) > hi_x) begin
      word = hi;
      sat = 1'b1;
    end else if ($signed(raw) < lo_x) begin
      word = lo;
      sat = 1'b1;
    end
  end
endmodule : mdc_clamp
`default_nettype wire

// ==== src/mdc_event_pins.sv ====
// event gating onto the push-pull and open-drain event pins
`timescale 1ns/10ps
`default_nettype none
module mdc_event_pins import mdc_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // gates and sources
  input wire logic [15:0] gates,
  input wire logic ready,
  input wire logic [SW_EVENTS-1:0] sw,
  input wire logic lateral,
  input wire logic conv,
  // pins
  output logic event_pin_q,
  output logic open_drain_event_pin_o_q,
  output logic open_drain_event_pin_oe_q
);
  logic any_event;

  always_comb begin
    // R7 ready gate
    any_event = ready & gates[EVEN_READY];
    // R8 switch gates
    any_event = any_event | (|(sw & gates[EVEN_SW_LSB +: SW_EVENTS]));
    // R9 lateral gate
    any_event = any_event | (lateral & gates[EVEN_LATERAL]);
    // R10 converter gate
    any_event = any_event | (conv & gates[EVEN_CONV]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_pin_q <= 1'b0;
      open_drain_event_pin_oe_q <= 1'b0;
    end else begin
      // R11 push-pull held low when off
      event_pin_q <= any_event & gates[EVEN_PP];
      // R12 open-drain released when off
      open_drain_event_pin_oe_q <= any_event & gates[EVEN_OD];
    end
  end

  // open-drain only ever pulls low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      open_drain_event_pin_o_q <= 1'b0;
    end else begin
      open_drain_event_pin_o_q <= 1'b0;
    end
  end
endmodule : mdc_event_pins
`default_nettype wire

// ==== src/mdc_regs.sv ====
// magnetometer measurement words, event enables and mode control
// ****************************************
// Notes on behaviour
// R1 - converter overflow flag is 1 when the converter overflowed, else 0
// R2 - each axis word is signed 16-bit, low byte in bits 7..0
// R3 - high-sensitivity range uses the full signed 16-bit span per axis
// R4 - wide range limits X and Y to +/-11264, Z keeps full span
// R5 - high sensitivity: out-of-span field clamps word and sets lateral flag
// R6 - wide range: X or Y beyond span clamps at 2c00/d400, sets flag
// R7 - event enable bit 0 gates ready events, resets to 1
// R8 - bits 1..6 gate switch events X1 X2 Y1 Y2 Z1 Z2, reset 0
// R9 - bit 7 gates lateral overflow events, resets to 0
// R10 - bit 8 gates converter overflow events, resets to 0
// R11 - bit 9 enables the push-pull pin, low when off, resets to 1
// R12 - bit 10 enables the open-drain pin, released when off, resets 1
// R13 - event enable bits 15..11 always read 0
// R14 - four-bit mode field: power-down, single, continuous 1..7; resets down
// R15 - control bit 4 picks sensor drive, 0 low noise, resets 0
// R16 - control bit 5 picks range, 0 high sensitivity, resets 0
// R17 - control bits 7 and 6 always read 0
// R18 - ready flag set on completed measurement, cleared by word read or setting access
// R19 - lateral flag is 1 when X and/or Y sensor overflowed, else 0; a Z overflow also sets it in high sensitivity
// R20 - unlisted mode codes act as power-down and start nothing
// ****************************************
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module mdc_regs import mdc_pkg::*; #(
  parameter int RAW_W = 18
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // converter front end
  input wire logic meas_done,
  input wire logic [RAW_W-1:0] raw_x,
  input wire logic [RAW_W-1:0] raw_y,
  input wire logic [RAW_W-1:0] raw_z,
  input wire logic adc_overflow,
  input wire logic [SW_EVENTS-1:0] switch_state,
  // sensor control
  output logic meas_start_q,
  output logic [3:0] mode_q_o,
  output logic drive_select_q,
  output logic range_select_q,
  // event pins
  output logic event_pin_q,
  output logic open_drain_event_pin_o_q,
  output logic open_drain_event_pin_oe_q
);
  // ****************************************
  // bus decode
  // ****************************************
  logic addr_ok;
  logic [7:0] idx;
  logic wr_pend_q;
  logic [7:0] wr_idx_q;
  logic rd_take;
  logic wr_data;

  // ****************************************
  // register state
  // ****************************************
  logic [15:0] event_enable_q;
  logic [7:0] mode_control_q;
  logic [15:0] x_field_word_q;
  logic [15:0] y_field_word_q;
  logic [15:0] z_field_word_q;
  logic data_ready_flag_q;
  logic lateral_sensor_overflow_flag_q;
  logic converter_overflow_flag_q;

  // ****************************************
  // measurement state and axis helpers
  // ****************************************
  logic busy_q;
  logic single_pend_q;

  // axis positions in the per-axis arrays
  localparam int AXES = 3;
  localparam int AXIS_X = 0;
  localparam int AXIS_Y = 1;
  localparam int AXIS_Z = 2;
  logic [RAW_W-1:0] raw_axis [AXES];
  logic [15:0] word_axis [AXES];
  logic [AXES-1:0] sat_axis;
  logic [15:0] word_x;
  logic [15:0] word_y;
  logic [15:0] word_z;
  logic sat_x;
  logic sat_y;
  logic sat_z;

  // decode and read helpers
  logic mode_valid;
  logic mode_cont;
  logic setting_access;
  logic word_read;
  logic [31:0] rd_mux;

  // idle and busy beats carry no transfer, so only nonseq and seq are taken
  assign addr_ok = hsel && hready
                   && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign idx = haddr[IDX_LSB +: 8];
  assign rd_take = addr_ok && !hwrite;
  assign wr_data = wr_pend_q;

  // only whole-word transfers are expected; narrower sizes act the same
  // write data comes a cycle later, so the index is kept for it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_idx_q <= idx;
    end
  end

  // zero wait states, always okay
  // nothing here can stall or fail, so unmapped indices are just ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (idx)
      IDX_STATUS: begin
        rd_mux[ST_READY] = data_ready_flag_q;
        // switch states already sit on this clock, no synchroniser
        rd_mux[ST_SW_LSB +: SW_EVENTS] = switch_state;
        rd_mux[ST_LATERAL] = lateral_sensor_overflow_flag_q;
        rd_mux[ST_CONV] = converter_overflow_flag_q;
      end
      // R2 word layout
      IDX_X_WORD: rd_mux[15:0] = x_field_word_q;
      IDX_Y_WORD: rd_mux[15:0] = y_field_word_q;
      IDX_Z_WORD: rd_mux[15:0] = z_field_word_q;
      // R13 top bits zero
      IDX_EVENT_ENABLE: rd_mux[15:0] = event_enable_q & EVEN_WMASK;
      // R17 top bits zero
      IDX_MODE_CONTROL: rd_mux[7:0] = mode_control_q & MODE_WMASK;
      // unmapped and left-out registers read zero
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data registered at the address phase, stands in the data phase
  // holding the last read keeps hrdata quiet between transfers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= rd_mux;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // R7 R8 R9 R10 R11 R12 reset values
      event_enable_q <= EVEN_RESET;
    end else if (wr_data && wr_idx_q == IDX_EVENT_ENABLE) begin
      // R13 upper bits fixed
      event_enable_q <= hwdata[15:0] & EVEN_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // R14 R15 R16 reset to power-down, low noise and high sensitivity
      mode_control_q <= MODE_RESET;
    end else if (wr_data && wr_idx_q == IDX_MODE_CONTROL) begin
      // R17 bits 7 and 6 fixed
      mode_control_q <= hwdata[7:0] & MODE_WMASK;
    end else if (meas_done && busy_q && mode_control_q[3:0] == MODE_SINGLE) begin
      // single measurement falls back to power-down once done
      // range and drive bits are kept for the next request
      mode_control_q <= {mode_control_q[7:4], MODE_POWER_DOWN};
    end
  end

  // every listed continuous code is even and nonzero
  // R14 mode decode
  assign mode_cont = (mode_control_q[0] == 1'b0) && (mode_control_q[3:0] != MODE_POWER_DOWN);
  // R20 unlisted codes start nothing
  assign mode_valid = mode_cont || (mode_control_q[3:0] == MODE_SINGLE);

  // unlisted codes reach the front end as power-down
  // R15 R16 drive and range outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q_o <= MODE_POWER_DOWN;
      drive_select_q <= 1'b0;
      range_select_q <= 1'b0;
    end else begin
      mode_q_o <= mode_valid ? mode_control_q[3:0] : MODE_POWER_DOWN;
      drive_select_q <= mode_control_q[MODE_DRIVE];
      range_select_q <= mode_control_q[MODE_RANGE];
    end
  end

  // ****************************************
  // measurement sequencing
  // ****************************************
  // a single request waits here until its start pulse goes out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      single_pend_q <= 1'b0;
    end else if (wr_data && wr_idx_q == IDX_MODE_CONTROL) begin
      single_pend_q <= (hwdata[3:0] == MODE_SINGLE);
    end else if (meas_start_q) begin
      single_pend_q <= 1'b0;
    end
  end

  // continuous modes restart as soon as the previous sample lands
  // one request in flight at most: the front end keeps no queue
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meas_start_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      // R20 start only in a listed mode
      meas_start_q <= !busy_q && !meas_start_q && mode_valid
                      && (mode_cont || single_pend_q);
      // busy spans request to sample; stray done pulses are ignored
      if (meas_start_q) begin
        busy_q <= 1'b1;
      end else if (meas_done) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // axis words and flags
  // ****************************************
  // R3 R4 R5 R6 clamp per range
  assign raw_axis[AXIS_X] = raw_x;
  assign raw_axis[AXIS_Y] = raw_y;
  assign raw_axis[AXIS_Z] = raw_z;

  // z keeps the full span in wide range, so only x and y narrow
  for (genvar a = 0; a < AXES; a++) begin : g_axis
    mdc_clamp #(
      .RAW_W(RAW_W),
      .LATERAL(a != AXIS_Z)
    ) u_clamp (
      .raw(raw_axis[a]),
      .wide(mode_control_q[MODE_RANGE]),
      .word(word_axis[a]),
      .sat(sat_axis[a])
    );
  end

  assign word_x = word_axis[AXIS_X];
  assign word_y = word_axis[AXIS_Y];
  assign word_z = word_axis[AXIS_Z];
  assign sat_x = sat_axis[AXIS_X];
  assign sat_y = sat_axis[AXIS_Y];
  assign sat_z = sat_axis[AXIS_Z];

  // a sample only counts when this block asked for it
  // flags are replaced per sample, so a clean sample clears them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      x_field_word_q <= 16'h0000;
      y_field_word_q <= 16'h0000;
      z_field_word_q <= 16'h0000;
      lateral_sensor_overflow_flag_q <= 1'b0;
      converter_overflow_flag_q <= 1'b0;
    end else if (meas_done && busy_q) begin
      // R2 words captured
      x_field_word_q <= word_x;
      y_field_word_q <= word_y;
      z_field_word_q <= word_z;
      // R5 R6 R19 lateral overflow, z counts only in high sensitivity
      lateral_sensor_overflow_flag_q <= sat_x | sat_y
                                        | (sat_z & ~mode_control_q[MODE_RANGE]);
      // R1 converter overflow
      converter_overflow_flag_q <= adc_overflow;
    end
  end

  // R18 clear sources
  // any axis read clears the flag, so read all three words in a row
  assign word_read = rd_take && (idx == IDX_X_WORD || idx == IDX_Y_WORD
                                 || idx == IDX_Z_WORD);
  // reads of the settings count as access, not only writes
  assign setting_access = addr_ok && (idx == IDX_EVENT_ENABLE || idx == IDX_MODE_CONTROL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_ready_flag_q <= 1'b0;
    end else if (meas_done && busy_q) begin
      // R18 set wins over clear
      data_ready_flag_q <= 1'b1;
    end else if (word_read || setting_access) begin
      // R18 cleared by read or access
      data_ready_flag_q <= 1'b0;
    end
  end

  // ****************************************
  // event pins
  // ****************************************
  // pins are registered inside, one cycle behind flags and gates
  mdc_event_pins u_pins (
    .hclk(hclk),
    .hresetn(hresetn),
    .gates(event_enable_q),
    .ready(data_ready_flag_q),
    .sw(switch_state),
    .lateral(lateral_sensor_overflow_flag_q),
    .conv(converter_overflow_flag_q),
    .event_pin_q(event_pin_q),
    .open_drain_event_pin_o_q(open_drain_event_pin_o_q),
    .open_drain_event_pin_oe_q(open_drain_event_pin_oe_q)
  );
endmodule : mdc_regs
`default_nettype wire

// ==== tb/mdc_regs_checker.sv ====
// assertion checker for the magnetometer register block
`timescale 1ns/10ps
`default_nettype none
module mdc_regs_checker import mdc_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // sensor side
  input wire logic meas_done,
  input wire logic meas_start_q,
  input wire logic [3:0] mode_q_o,
  input wire logic drive_select_q,
  input wire logic range_select_q,
  input wire logic event_pin_q,
  input wire logic open_drain_event_pin_o_q,
  input wire logic open_drain_event_pin_oe_q
);
  // ****************************************
  // data phase tracking
  // ****************************************
  logic rd_v_q;
  logic wr_v_q;
  logic [7:0] idx_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_v_q <= 1'b0;
      wr_v_q <= 1'b0;
      idx_q <= 8'h00;
    end else if (hready) begin
      rd_v_q <= hsel && htrans[1] && !hwrite;
      wr_v_q <= hsel && htrans[1] && hwrite;
      idx_q <= haddr[9:2];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************************************
  // assertions
  // ****************************************
  mode_legal_a: assert property (mode_q_o == 4'h0 || mode_q_o == 4'h1 || !mode_q_o[0])
    else $error("mode output shows an unlisted code");
  start_mode_a: assert property (meas_start_q |-> mode_q_o != MODE_POWER_DOWN)
    else $error("sample requested in power-down");
  od_low_a: assert property (!open_drain_event_pin_o_q)
    else $error("open-drain pin driven high");
  ctl_read_a: assert property (rd_v_q && idx_q == IDX_MODE_CONTROL |-> hrdata[31:6] == 26'h0)
    else $error("control read shows fixed bits set");
  even_read_a: assert property (rd_v_q && idx_q == IDX_EVENT_ENABLE |-> hrdata[31:11] == 21'h0)
    else $error("event enable read shows fixed bits set");
  ctl_write_a: assert property (wr_v_q && idx_q == IDX_MODE_CONTROL |-> ##2
    drive_select_q == $past(hwdata[4], 2) && range_select_q == $past(hwdata[5], 2))
    else $error("drive or range not taken from write");
  pp_off_a: assert property (wr_v_q && idx_q == IDX_EVENT_ENABLE && !hwdata[9] |-> ##2 !event_pin_q)
    else $error("push-pull pin high while disabled");
  od_off_a: assert property (wr_v_q && idx_q == IDX_EVENT_ENABLE && !hwdata[10] |->
    ##2 !open_drain_event_pin_oe_q)
    else $error("open-drain pin pulled while disabled");
  single_end_a: assert property (meas_done && mode_q_o == MODE_SINGLE |-> ##2 mode_q_o == 4'h0)
    else $error("single mode did not return to power-down");
  cont_again_a: assert property (meas_done && !mode_q_o[0] && mode_q_o != 4'h0 |->
    ##[1:3] meas_start_q)
    else $error("continuous mode did not request again");
endmodule : mdc_regs_checker
bind mdc_regs mdc_regs_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .meas_done(meas_done), .meas_start_q(meas_start_q), .mode_q_o(mode_q_o),
  .drive_select_q(drive_select_q), .range_select_q(range_select_q),
  .event_pin_q(event_pin_q), .open_drain_event_pin_o_q(open_drain_event_pin_o_q),
  .open_drain_event_pin_oe_q(open_drain_event_pin_oe_q));
`default_nettype wire

// ==== tb/mdc_front_model.sv ====
// converter front end model answering sample requests after a set lag
`timescale 1ns/10ps
`default_nettype none
module mdc_front_model #(
  parameter int RAW_W = 18
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // request and field values
  input wire logic meas_start_q,
  input wire logic [7:0] lag,
  input wire logic [RAW_W-1:0] fx,
  input wire logic [RAW_W-1:0] fy,
  input wire logic [RAW_W-1:0] fz,
  input wire logic fovf,
  // samples
  output logic meas_done,
  output logic [RAW_W-1:0] raw_x,
  output logic [RAW_W-1:0] raw_y,
  output logic [RAW_W-1:0] raw_z,
  output logic adc_overflow
);
  // ****************************************
  // conversion timing
  // ****************************************
  logic busy_q;
  logic [7:0] cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      meas_done <= 1'b0;
    end else begin
      meas_done <= 1'b0;
      if (meas_start_q) begin
        busy_q <= 1'b1;
        cnt_q <= lag;
      end else if (busy_q && cnt_q == 8'h00) begin
        busy_q <= 1'b0;
        meas_done <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
  // samples only hold with the done pulse, inverted garbage otherwise
  assign raw_x = meas_done ? fx : ~fx;
  assign raw_y = meas_done ? fy : ~fy;
  assign raw_z = meas_done ? fz : ~fz;
  assign adc_overflow = meas_done ? fovf : ~fovf;
endmodule : mdc_front_model
`default_nettype wire

// ==== tb/mdc_regs_tb_top.sv ====
// self-checking bench for the magnetometer register block
`timescale 1ns/10ps
`default_nettype none
module mdc_regs_tb_top import mdc_pkg::*;;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [17:0] fx = 18'h0, fy = 18'h0, fz = 18'h0;
  logic [7:0] lag = 8'h00;
  logic fovf = 1'b0;
  logic [5:0] switch_state = 6'h00;
  logic [17:0] raw_x, raw_y, raw_z;
  logic [31:0] hrdata;
  logic [3:0] mode_q_o;
  logic hreadyout, hresp, meas_done, adc_overflow, meas_start_q;
  logic drive_select_q, range_select_q, event_pin_q, od_o, od_oe;
  int mismatches = 0;
  int n_compared = 0;
  int n_starts = 0;
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) if (meas_start_q === 1'b1) n_starts++;
  mdc_regs #(.RAW_W(18)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .meas_done(meas_done),
    .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z), .adc_overflow(adc_overflow),
    .switch_state(switch_state), .meas_start_q(meas_start_q), .mode_q_o(mode_q_o),
    .drive_select_q(drive_select_q), .range_select_q(range_select_q),
    .event_pin_q(event_pin_q), .open_drain_event_pin_o_q(od_o),
    .open_drain_event_pin_oe_q(od_oe));
  mdc_front_model #(.RAW_W(18)) u_front (.hclk(hclk), .hresetn(hresetn),
    .meas_start_q(meas_start_q), .lag(lag), .fx(fx), .fy(fy), .fz(fz), .fovf(fovf),
    .meas_done(meas_done), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
    .adc_overflow(adc_overflow));
  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", hresp, 32'h0);
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] u;
    bus(idx, 1'b1, d, u);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] d;
    bus(idx, 1'b0, 32'h0, d);
    chk(what, d, exp);
  endtask : rdc
  task automatic end_sim();
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    int s;
    rdc(IDX_EVENT_ENABLE, 32'h0601, "enable reset");
    rdc(IDX_MODE_CONTROL, 32'h0, "control reset");
    chk("pins", {od_oe, event_pin_q}, 32'h0);
    wr(IDX_EVENT_ENABLE, 32'hffff_ffff);
    rdc(IDX_EVENT_ENABLE, 32'h07ff, "enable");
    s = n_starts;
    wr(IDX_MODE_CONTROL, 32'hffff_ffff);
    rdc(IDX_MODE_CONTROL, 32'h3f, "control");
    chk("drive range", {range_select_q, drive_select_q}, 32'h3);
    chk("unlisted mode", {28'(n_starts - s), mode_q_o}, 32'h0);
    wr(IDX_MODE_CONTROL, 32'h0);
    wr(8'h30, 32'hffff_ffff);
    rdc(8'h30, 32'h0, "unmapped");
    wr(IDX_X_WORD, 32'h1234);
    rdc(IDX_X_WORD, 32'h0, "x word");
    chk("drive range", {range_select_q, drive_select_q}, 32'h0);
  endtask : t_regs
  task automatic t_meas(input logic wide, input logic [15:0] g, input int x, input int y,
      input int z, input logic ovf, input logic [47:0] ew, input logic lat);
    logic ev;
    fx <= x[17:0];
    fy <= y[17:0];
    fz <= z[17:0];
    fovf <= ovf;
    lag <= wide ? 8'd20 : 8'd0;
    wr(IDX_EVENT_ENABLE, {16'h0, g});
    wr(IDX_MODE_CONTROL, {26'h0, wide, 5'h01});
    @(posedge hclk);
    // the effective mode shows single a cycle after the write lands
    for (int k = 0; k < 60 && mode_q_o !== MODE_SINGLE; k++) @(posedge hclk);
    chk("single mode", mode_q_o, 32'h1);
    for (int k = 0; k < 60 && mode_q_o !== MODE_POWER_DOWN; k++) @(posedge hclk);
    chk("single return", mode_q_o, 32'h0);
    repeat (2) @(posedge hclk);
    ev = g[0] | (lat & g[7]) | (ovf & g[8]);
    chk("push-pull pin", event_pin_q, g[9] & ev);
    chk("open-drain pin", od_oe, g[10] & ev);
    rdc(IDX_STATUS, {23'h0, ovf, lat, 7'h01}, "status");
    rdc(IDX_X_WORD, {16'h0, ew[47:32]}, "x word");
    rdc(IDX_Y_WORD, {16'h0, ew[31:16]}, "y word");
    rdc(IDX_Z_WORD, {16'h0, ew[15:0]}, "z word");
    rdc(IDX_STATUS, {23'h0, ovf, lat, 7'h00}, "status read");
    chk("pin read", event_pin_q, g[9] & ((lat & g[7]) | (ovf & g[8])));
  endtask : t_meas
  task automatic t_switch();
    for (int i = 0; i < 6; i++) begin
      wr(IDX_EVENT_ENABLE, 32'h0200 | (32'h2 << i));
      switch_state <= 6'h01 << i;
      repeat (3) @(posedge hclk);
      chk("switch gated", event_pin_q, 32'h1);
      switch_state <= 6'h01 << ((i + 1) % 6);
      repeat (3) @(posedge hclk);
      chk("switch masked", event_pin_q, 32'h0);
    end
    switch_state <= 6'h00;
  endtask : t_switch
  task automatic t_cont();
    logic [3:0] codes [7] = '{4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc, 4'he};
    int s;
    lag <= 8'd6;
    foreach (codes[i]) begin
      wr(IDX_MODE_CONTROL, {28'h0, codes[i]});
      s = n_starts;
      repeat (40) @(posedge hclk);
      chk("continuous mode", mode_q_o, codes[i]);
      chk("repeat starts", n_starts - s >= 3, 32'h1);
      // stop right after a request so no sample is due mid-write
      for (int k = 0; k < 40 && meas_start_q !== 1'b1; k++) @(posedge hclk);
      wr(IDX_MODE_CONTROL, 32'h0);
      repeat (12) @(posedge hclk);
      s = n_starts;
      repeat (20) @(posedge hclk);
      chk("power-down idle", {28'(n_starts - s), mode_q_o}, 32'h0);
    end
  endtask : t_cont
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_meas(1'b0, 16'h0601, 40000, -40000, -1, 1'b0, 48'h7fff_8000_ffff, 1'b1);
    t_meas(1'b0, 16'h0300, 32767, -32768, 0, 1'b1, 48'h7fff_8000_0000, 1'b0);
    t_meas(1'b1, 16'h0680, 11265, -11264, 40000, 1'b0, 48'h2c00_d400_7fff, 1'b1);
    t_meas(1'b1, 16'h0001, 11264, -11264, -40000, 1'b0, 48'h2c00_d400_8000, 1'b0);
    t_switch();
    t_cont();
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge hclk);
    mismatches++;
    end_sim();
  end
endmodule : mdc_regs_tb_top
`default_nettype wire
